// File: include/asf_pkg.sv
`default_nettype none
package asf_pkg;
  localparam int NCH = 8;
  localparam int CHAN_W = 3;
  localparam int CODE_W = 16;
  localparam int TAG_W = 4;
  localparam int OUT_W = CODE_W + TAG_W;
  localparam int FIFO_W = CHAN_W + CODE_W;
  localparam int CMP_W = CODE_W + 2;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] LAST_CFG_EDGE = 5'h0F;
  localparam int CFG_WR_BIT = 15;
  localparam int CFG_FMT_BIT = 4;
  localparam int CFG_CHAN_LSB = 0;
  localparam logic [CHAN_W-1:0] CHAN_DEF = 3'h0;
  localparam logic FMT_DEF = 1'h0;
  localparam logic signed [CMP_W-1:0] HI_CLR_OFS = 18'sh00002;
  localparam logic signed [CMP_W-1:0] LO_SET_OFS = 18'sh00001;
  localparam logic signed [CMP_W-1:0] LO_CLR_OFS = 18'sh00001;
  localparam int CLK_PERIOD_NS = 25;
  localparam int RST_MIN_NS = 40;
  localparam int PD_MIN_NS = 400;
  localparam logic [CNT_W-1:0] RST_MIN_CYC = CNT_W'((RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] PD_CYC = CNT_W'((PD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int SYNC_W = 5;
  localparam int S_CS = 0;
  localparam int S_SCLK = 1;
  localparam int S_SDI = 2;
  localparam int S_DAISY = 3;
  localparam int S_RPD = 4;
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 5'h13;
  typedef enum logic [1:0] {ST_IDLE, ST_CFG, ST_DATA} asf_state_e;
endpackage
`default_nettype wire

// File: hw/asf_fifo2.sv
`default_nettype none
module asf_fifo2 #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem [2];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] cnt;
  logic not_full;
  logic not_empty;
  wire push = in_valid & not_full;
  wire pop = out_ready & not_empty;
  wire [1:0] next_cnt = cnt + {1'b0, push} - {1'b0, pop};

  assign in_ready = not_full;
  assign out_valid = not_empty;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Flags kept as flops so ready reaches the source without a gate
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      cnt <= 2'h0;
      not_full <= 1'b1;
      not_empty <= 1'b0;
    end else begin
      wr_ptr <= wr_ptr ^ push;
      rd_ptr <= rd_ptr ^ pop;
      cnt <= next_cnt;
      not_full <= next_cnt != 2'h2;
      not_empty <= next_cnt != 2'h0;
    end
  end
endmodule
`default_nettype wire

// File: hw/asf_top.sv
`default_nettype none
module asf_top (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic SDI,
  input wire logic DAISY,
  input wire logic RESET_POWERDOWN_PIN_N,
  output logic SDO,
  output logic SDO_OE,
  input wire logic [asf_pkg::CODE_W-1:0] CONV_RESULT,
  input wire logic CONV_VALID,
  output logic CONV_READY,
  output logic CONV_START,
  output logic [asf_pkg::CHAN_W-1:0] CONV_CHANNEL,
  input wire logic [asf_pkg::NCH*asf_pkg::CODE_W-1:0] HIGH_THRESH,
  input wire logic [asf_pkg::NCH*asf_pkg::CODE_W-1:0] HIGH_HYST,
  input wire logic [asf_pkg::NCH*asf_pkg::CODE_W-1:0] LOW_THRESH,
  input wire logic [asf_pkg::NCH*asf_pkg::CODE_W-1:0] LOW_HYST,
  input wire logic FLAG_READ,
  output logic [asf_pkg::NCH-1:0] ACTIVE_HIGH,
  output logic [asf_pkg::NCH-1:0] ACTIVE_LOW,
  output logic [asf_pkg::NCH-1:0] TRIPPED_HIGH,
  output logic [asf_pkg::NCH-1:0] TRIPPED_LOW,
  output logic ALARM,
  output logic POWER_DOWN
);
  import asf_pkg::*;

  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic cs_d;
  logic sclk_d;
  logic [CNT_W-1:0] rpd_cnt;
  asf_state_e state;
  logic [CNT_W-1:0] edge_cnt;
  localparam int CFG_BITS_W = int'(LAST_CFG_EDGE) + 1;
  logic [CFG_BITS_W-1:0] cfg_sr;
  logic [CHAN_W-1:0] pend_chan;
  logic pend_fmt;
  logic cur_fmt;
  logic [OUT_W-1:0] out_sr;
  logic fifo_valid;
  logic [FIFO_W-1:0] fifo_dout;
  logic [NCH-1:0] nact_hi;
  logic [NCH-1:0] nact_lo;
  logic [NCH-1:0] trip_hi;
  logic [NCH-1:0] trip_lo;

  // Pins come from outside the clock domain
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      sync_a <= SYNC_IDLE;
      sync_b <= SYNC_IDLE;
    end else begin
      sync_a <= {RESET_POWERDOWN_PIN_N, DAISY, SDI, SCLK, CS_N};
      sync_b <= sync_a;
    end
  end

  wire cs_s = sync_b[S_CS];
  wire sclk_s = sync_b[S_SCLK];
  wire sdi_s = sync_b[S_SDI];
  wire daisy_s = sync_b[S_DAISY];
  wire rpd_low = ~sync_b[S_RPD];

  // Reset pin decoded by low-pulse width
  wire [CNT_W-1:0] next_rpd_cnt = !rpd_low ? '0 : (rpd_cnt == PD_CYC) ? rpd_cnt : rpd_cnt + 1'b1;
  wire prog_rst = !rpd_low && rpd_cnt >= RST_MIN_CYC;

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      rpd_cnt <= '0;
      POWER_DOWN <= 1'b0;
    end else begin
      rpd_cnt <= next_rpd_cnt;
      POWER_DOWN <= rpd_low & (POWER_DOWN | (next_rpd_cnt == PD_CYC));
    end
  end

  // Frame strobes; all but cs_rise gated off while powered down
  wire cs_fall = cs_d & ~cs_s & ~POWER_DOWN;
  wire cs_rise = ~cs_d & cs_s;
  wire sclk_fall = sclk_d & ~sclk_s & ~cs_s & ~POWER_DOWN;
  wire edge16 = sclk_fall && state == ST_CFG && edge_cnt == LAST_CFG_EDGE;
  wire data_shift = sclk_fall && state == ST_DATA;
  wire [CFG_BITS_W-1:0] cfg_word = {cfg_sr[CFG_BITS_W-2:0], sdi_s};
  wire cfg_write = edge16 && cfg_word[CFG_WR_BIT];
  wire [FIFO_W-1:0] push_data = {CONV_CHANNEL, CONV_RESULT};
  wire push = CONV_VALID & CONV_READY;
  wire [CODE_W-1:0] pop_code = fifo_valid ? fifo_dout[CODE_W-1:0] : '0;
  wire [CHAN_W-1:0] pop_chan = fifo_valid ? fifo_dout[FIFO_W-1:CODE_W] : '0;
  wire [OUT_W-1:0] load_word = {pop_code, {(TAG_W - CHAN_W){1'b0}}, pop_chan};
  // Chain bit enters right behind the active frame length
  wire [OUT_W-1:0] next_out_sr = cur_fmt ? {out_sr[OUT_W-2:0], daisy_s}
    : {out_sr[OUT_W-2:TAG_W], daisy_s, {TAG_W{1'b0}}};
  wire [NCH-1:0] any_trip = TRIPPED_HIGH | TRIPPED_LOW;

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      cs_d <= 1'b1;
      sclk_d <= 1'b1;
    end else begin
      cs_d <= cs_s;
      sclk_d <= sclk_s;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST || POWER_DOWN || cs_rise) begin
      state <= ST_IDLE;
      edge_cnt <= '0;
    end else if (cs_fall) begin
      state <= ST_CFG;
      edge_cnt <= '0;
    end else if (sclk_fall && state == ST_CFG) begin
      edge_cnt <= edge_cnt + 1'b1;
      if (edge16) begin
        state <= ST_DATA;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST || prog_rst) begin
      cfg_sr <= '0;
      pend_chan <= CHAN_DEF;
      pend_fmt <= FMT_DEF;
      cur_fmt <= FMT_DEF;
      CONV_CHANNEL <= CHAN_DEF;
    end else begin
      if (sclk_fall && state == ST_CFG) begin
        cfg_sr <= cfg_word;
      end
      if (cfg_write) begin
        pend_chan <= cfg_word[CFG_CHAN_LSB +: CHAN_W];
        pend_fmt <= cfg_word[CFG_FMT_BIT];
      end
      if (cs_fall) begin
        CONV_CHANNEL <= pend_chan;
        cur_fmt <= pend_fmt;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      CONV_START <= 1'b0;
      SDO_OE <= 1'b0;
      out_sr <= '0;
    end else begin
      CONV_START <= cs_fall;
      SDO_OE <= ~POWER_DOWN & ~cs_s & (SDO_OE | cs_fall);
      if (cs_fall || cs_rise || POWER_DOWN) begin
        out_sr <= '0;
      end else if (edge16) begin
        out_sr <= load_word;
      end else if (data_shift) begin
        out_sr <= next_out_sr;
      end
    end
  end

  assign SDO = out_sr[OUT_W-1];

  // Result buffer lets a late pop lose no conversion
  asf_fifo2 #(.W(FIFO_W)) u_buf (
    .clk(CLOCK),
    .rst(SYS_RST),
    .in_valid(CONV_VALID),
    .in_ready(CONV_READY),
    .in_data(push_data),
    .out_valid(fifo_valid),
    .out_ready(edge16),
    .out_data(fifo_dout)
  );

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    // Two guard bits keep threshold sums from wrapping
    wire signed [CMP_W-1:0] code = $signed({2'b00, CONV_RESULT});
    wire signed [CMP_W-1:0] ht = $signed({2'b00, HIGH_THRESH[i*CODE_W +: CODE_W]});
    wire signed [CMP_W-1:0] hh = $signed({2'b00, HIGH_HYST[i*CODE_W +: CODE_W]});
    wire signed [CMP_W-1:0] lt = $signed({2'b00, LOW_THRESH[i*CODE_W +: CODE_W]});
    wire signed [CMP_W-1:0] lh = $signed({2'b00, LOW_HYST[i*CODE_W +: CODE_W]});
    wire hit = push && CONV_CHANNEL == CHAN_W'(i);
    wire hi_set = code > ht + hh;
    wire hi_clr = code <= ht - hh - HI_CLR_OFS;
    wire lo_set = code < lt - lh - LO_SET_OFS;
    wire lo_clr = code >= lt + lh + LO_CLR_OFS;
    assign nact_hi[i] = hit ? (ACTIVE_HIGH[i] ? ~hi_clr : hi_set) : ACTIVE_HIGH[i];
    assign nact_lo[i] = hit ? (ACTIVE_LOW[i] ? ~lo_clr : lo_set) : ACTIVE_LOW[i];
    assign trip_hi[i] = hit & nact_hi[i];
    assign trip_lo[i] = hit & nact_lo[i];
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST || prog_rst) begin
      ACTIVE_HIGH <= '0;
      ACTIVE_LOW <= '0;
      TRIPPED_HIGH <= '0;
      TRIPPED_LOW <= '0;
      ALARM <= 1'b0;
    end else begin
      ACTIVE_HIGH <= nact_hi;
      ACTIVE_LOW <= nact_lo;
      // A new trip wins over a read in the same cycle
      TRIPPED_HIGH <= (TRIPPED_HIGH & ~{NCH{FLAG_READ}}) | trip_hi;
      TRIPPED_LOW <= (TRIPPED_LOW & ~{NCH{FLAG_READ}}) | trip_lo;
      if (edge16) begin
        ALARM <= |any_trip;
      end
    end
  end

  wire hit_ch0 = g_ch[0].hit;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);

  sequence s_frame_open;
    cs_fall ##1 CONV_START;
  endsequence

  sequence s_cfg_done;
    edge16 ##1 state == ST_DATA;
  endsequence

  a_alarm_edge_only: assert property ($changed(ALARM) |-> $past(edge16) || $past(prog_rst))
    else $error("alarm moved off the 16th edge");
  a_alarm_value: assert property (edge16 && !prog_rst |=> ALARM == $past(|any_trip))
    else $error("alarm does not follow tripped flags");
  a_sdo_low_cfg: assert property (state == ST_CFG |-> !SDO)
    else $error("serial output not low before 16th edge");
  a_sdo_msb_out: assert property (edge16 && fifo_valid |=> SDO == $past(fifo_dout[CODE_W-1]))
    else $error("result msb not presented on 16th edge");
  a_frame_start: assert property (s_frame_open |-> SDO_OE && CONV_CHANNEL == $past(pend_chan))
    else $error("frame start did not convert pending channel");
  a_cfg_defer: assert property (cfg_write |=> CONV_CHANNEL == $past(CONV_CHANNEL) && !CONV_START)
    else $error("config applied inside the frame");
  a_daisy_shift: assert property (s_cfg_done ##0 (cur_fmt ##[1:40] data_shift) |=> out_sr[0] == $past(daisy_s))
    else $error("chain input not captured");
  a_pd_entry: assert property (rpd_low && rpd_cnt == PD_CYC - 1'b1 |=> POWER_DOWN)
    else $error("long reset low did not power down");
  a_pd_ignore: assert property (POWER_DOWN |=> !CONV_START && !SDO_OE && state == ST_IDLE)
    else $error("activity accepted while powered down");
  a_trip_latch: assert property (|trip_hi && !prog_rst |=> (TRIPPED_HIGH & $past(trip_hi)) == $past(trip_hi))
    else $error("trip lost against a flag read");
  a_hi_set: assert property (hit_ch0 && !ACTIVE_HIGH[0] && g_ch[0].hi_set && !prog_rst |=> ACTIVE_HIGH[0])
    else $error("high alarm failed to set");
endmodule
`default_nettype wire

// File: dv/asf_host_model.sv
`default_nettype none
module asf_host_model (
  input wire logic CLOCK,
  input wire logic SDO,
  input wire logic SDO_OE,
  output logic CS_N,
  output logic SCLK,
  output logic SDI
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    CS_N = 1'b1;
    SCLK = 1'b1;
    SDI = 1'b0;
  end
  task automatic half();
    repeat (4) @(negedge CLOCK);
  endtask
  // Serial clock idles high and only runs inside a frame
  task automatic frame(input logic [15:0] cfg, input int n, output logic [63:0] rx, output logic oe);
    rx = '0;
    oe = 1'b1;
    @(negedge CLOCK);
    CS_N = 1'b0;
    SDI = cfg[15];
    half();
    half();
    for (int k = 1; k <= n; k++) begin
      SCLK = 1'b0;
      // No pull on the line, so a released output reads as the inverse
      rx = {rx[62:0], SDO_OE ? SDO : ~SDO};
      oe = oe & SDO_OE;
      half();
      SCLK = 1'b1;
      // Released data line toggles so a late sample cannot look valid
      SDI = (k < 16) ? cfg[15-k] : ~SDI;
      half();
    end
    CS_N = 1'b1;
    SDI = ~SDI;
    repeat (8) @(negedge CLOCK);
  endtask
endmodule
`default_nettype wire

// File: dv/asf_top_test.sv
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module asf_top_test import asf_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLOCK = 1'b0;
  logic SYS_RST = 1'b1;
  logic DAISY = 1'b0;
  logic RESET_POWERDOWN_PIN_N = 1'b1;
  logic CONV_VALID = 1'b0;
  logic FLAG_READ = 1'b0;
  logic [CODE_W-1:0] CONV_RESULT = '0;
  logic [NCH*CODE_W-1:0] HIGH_THRESH = {NCH{16'h1000}};
  logic [NCH*CODE_W-1:0] HIGH_HYST = {NCH{16'h0010}};
  logic [NCH*CODE_W-1:0] LOW_THRESH = {NCH{16'h0100}};
  logic [NCH*CODE_W-1:0] LOW_HYST = {NCH{16'h0004}};
  logic CS_N, SCLK, SDI, SDO, SDO_OE, CONV_READY, CONV_START, ALARM, POWER_DOWN, oe;
  logic [CHAN_W-1:0] CONV_CHANNEL;
  logic [NCH-1:0] ACTIVE_HIGH, ACTIVE_LOW, TRIPPED_HIGH, TRIPPED_LOW;
  logic [63:0] rx;
  logic [15:0] codes [8] = '{16'h1010, 16'h1011, 16'h0FEF, 16'h0FEE, 16'h00FB, 16'h00FA, 16'h0104, 16'h0105};
  logic [1:0] exp_act [8] = '{2'b00, 2'b10, 2'b10, 2'b00, 2'b00, 2'b01, 2'b01, 2'b00};
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  int starts = 0;
  int nfr = 0;

  asf_top u_dut (.CLOCK, .SYS_RST, .CS_N, .SCLK, .SDI, .DAISY, .RESET_POWERDOWN_PIN_N, .SDO, .SDO_OE, .CONV_RESULT,
    .CONV_VALID, .CONV_READY, .CONV_START, .CONV_CHANNEL, .HIGH_THRESH, .HIGH_HYST, .LOW_THRESH, .LOW_HYST,
    .FLAG_READ, .ACTIVE_HIGH, .ACTIVE_LOW, .TRIPPED_HIGH, .TRIPPED_LOW, .ALARM, .POWER_DOWN);
  asf_host_model u_host (.CLOCK, .SDO, .SDO_OE, .CS_N, .SCLK, .SDI);

  always #12.5 CLOCK = ~CLOCK;

  task automatic end_sim();
    $display("errors=%0d compares=%0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge CLOCK) begin
    cyc++;
    if (CONV_START === 1'b1) starts++;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end

  // Ready is sampled mid-cycle, so it is the value the next edge sees
  task automatic push(input logic [15:0] code);
    logic rdy;
    @(negedge CLOCK);
    CONV_RESULT = code;
    CONV_VALID = 1'b1;
    forever begin
      rdy = CONV_READY;
      @(negedge CLOCK);
      if (rdy === 1'b1) break;
    end
    CONV_VALID = 1'b0;
  endtask

  task automatic frm(input logic [15:0] cfg, input int n, input logic [63:0] exp);
    u_host.frame(cfg, n, rx, oe);
    nfr++;
    `CHK(rx, exp)
    `CHK({oe, SDO_OE}, 2'b10)
  endtask

  task automatic pin_low(input int n);
    @(negedge CLOCK);
    RESET_POWERDOWN_PIN_N = 1'b0;
    repeat (n) @(negedge CLOCK);
  endtask

  initial begin
    HIGH_THRESH[5*CODE_W +: CODE_W] = 16'h2000;
    repeat (2) @(negedge CLOCK);
    SYS_RST = 1'b0;
    repeat (3) @(negedge CLOCK);
    `CHK({SDO_OE, ALARM, POWER_DOWN, CONV_CHANNEL}, 6'h00)
    for (int i = 0; i < 8; i++) begin
      push(codes[i]);
      `CHK({ACTIVE_HIGH[0], ACTIVE_LOW[0]}, exp_act[i])
      `CHK(ALARM, 1'(i >= 2))
      frm(16'h0000, 34, {46'h0, codes[i], 2'b00});
      `CHK(ALARM, 1'(i >= 1))
    end
    `CHK({TRIPPED_HIGH[0], TRIPPED_LOW[0]}, 2'b11)
    @(negedge CLOCK);
    FLAG_READ = 1'b1;
    @(negedge CLOCK);
    FLAG_READ = 1'b0;
    @(negedge CLOCK);
    `CHK({TRIPPED_HIGH, TRIPPED_LOW}, 16'h0000)
    frm(16'h8005, 34, 64'h0);
    `CHK({ALARM, CONV_CHANNEL}, 4'h0)
    frm(16'h0000, 34, 64'h0);
    `CHK(CONV_CHANNEL, 3'h5)
    push(16'h1800);
    `CHK(ACTIVE_HIGH, 8'h00)
    push(16'h2011);
    `CHK({ACTIVE_HIGH, CONV_READY}, 9'h040)
    frm(16'h8015, 34, {46'h0, 16'h1800, 2'b00});
    DAISY = 1'b1;
    frm(16'h0000, 38, {42'h0, 16'h2011, 4'h5, 2'b11});
    DAISY = 1'b0;
    `CHK({ALARM, TRIPPED_HIGH[5]}, 2'b11)
    pin_low(3);
    RESET_POWERDOWN_PIN_N = 1'b1;
    repeat (6) @(negedge CLOCK);
    `CHK({POWER_DOWN, CONV_CHANNEL, TRIPPED_HIGH}, 12'h000)
    pin_low(20);
    `CHK(POWER_DOWN, 1'b1)
    u_host.frame(16'h8003, 20, rx, oe);
    `CHK(oe, 1'b0)
    RESET_POWERDOWN_PIN_N = 1'b1;
    repeat (6) @(negedge CLOCK);
    `CHK(POWER_DOWN, 1'b0)
    frm(16'h8000, 34, 64'h0);
    `CHK(CONV_CHANNEL, 3'h0)
    `CHK(starts, nfr)
    end_sim();
  end
endmodule
`default_nettype wire
